// ==== hdl/ccs_channel.sv ====
// control and status engine of one dma channel
//
// Decided for this implementation: the plain strobed port.
module ccs_channel (
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_rst,
  input  wire logic [ccs_pkg::C_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]                  i_wdata,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  output logic      [31:0]                  o_rdata,
  input  wire logic [ccs_pkg::C_PERIPHERAL_DATA_REQUEST_N-1:0] i_peripheral_data_request,
  input  wire logic [3:0]                   i_timer,
  input  wire logic                         i_chain_in,
  input  wire logic                         i_sniff_on,
  input  wire logic [3:0]                   i_sniff_chan,
  output logic                              o_rd_req,
  output logic      [31:0]                  o_rd_addr,
  input  wire logic                         i_rd_ack,
  input  wire logic                         i_rd_err,
  input  wire logic [31:0]                  i_rd_data,
  output logic                              o_wr_req,
  output logic      [31:0]                  o_wr_addr,
  output logic      [31:0]                  o_wr_data,
  input  wire logic                         i_wr_ack,
  input  wire logic                         i_wr_err,
  output logic      [1:0]                   o_size,
  output logic                              o_busy,
  output logic                              o_irq,
  output logic                              o_chain_go,
  output logic      [3:0]                   o_chain_idx,
  output logic                              o_sniff_valid,
  output logic      [31:0]                  o_sniff_data
);
  import ccs_pkg::*;

  // ******************************************************
  // state
  // ******************************************************
  typedef struct packed {
    logic        en;
    logic        hipri;
    logic [1:0]  size;
    logic        src_step;
    logic        dst_step;
    logic [3:0]  ring_size;
    logic        ring_sel;
    logic [3:0]  chain;
    logic [5:0]  pace_sel;
    logic        quiet;
    logic        brev;
    logic        sniff;
    logic        busy;
    logic        rd_err;
    logic        wr_err;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] cnt;
    logic [31:0] data;
    ccs_state_t  state;
    logic        rd_req;
    logic        wr_req;
    logic [31:0] rdata;
    logic        irq;
    logic        chain_go;
    logic        sniff_v;
  } ccs_regs_t;

  ccs_regs_t s_r;
  ccs_regs_t s_nxt;

  ccs_path_if pif ();

  ccs_xfer_path u_path (
    .bus (pif.path)
  );

  logic wr_ctrl;
  logic wr_cnt;
  logic null_wr;
  logic abort;
  logic trigger;
  logic rd_fail;
  logic wr_fail;
  logic pace_en;
  logic sniff_hit;

  // ******************************************************
  // register read image
  // ******************************************************
  function automatic logic [31:0] ctrl_word(input ccs_regs_t s);
    logic [31:0] w;
    w                            = 32'h0;
    w[C_ANYERR_BIT]              = s.rd_err | s.wr_err;
    w[C_RDERR_BIT]               = s.rd_err;
    w[C_WRERR_BIT]               = s.wr_err;
    w[C_BUSY_BIT]                = s.busy;
    w[C_SNIFF_BIT]               = s.sniff;
    w[C_BREV_BIT]                = s.brev;
    w[C_QUIET_BIT]               = s.quiet;
    w[C_PACE_LSB +: 6]           = s.pace_sel;
    w[C_CHAIN_LSB +: 4]          = s.chain;
    w[C_RINGSEL_BIT]             = s.ring_sel;
    w[C_RING_LSB +: 4]           = s.ring_size;
    w[C_DSTSTEP_BIT]             = s.dst_step;
    w[C_SRCSTEP_BIT]             = s.src_step;
    w[C_SIZE_LSB +: 2]           = s.size;
    w[C_HIPRI_BIT]               = s.hipri;
    w[C_EN_BIT]                  = s.en;
    ctrl_word                    = w;
  endfunction

  assign pif.size      = s_r.size;
  assign pif.brev      = s_r.brev;
  assign pif.ring_size = s_r.ring_size;
  assign pif.ring_sel  = s_r.ring_sel;
  assign pif.src_step  = s_r.src_step;
  assign pif.dst_step  = s_r.dst_step;
  assign pif.src       = s_r.src;
  assign pif.dst       = s_r.dst;
  assign pif.raw_data  = i_rd_data;
  assign pif.pace_sel  = s_r.pace_sel;
  assign pif.peripheral_data_request      = i_peripheral_data_request;
  assign pif.timer     = i_timer;

  assign wr_ctrl   = i_wr && (i_addr == C_OFS_CTRL);
  assign wr_cnt    = i_wr && (i_addr == C_OFS_CNT);
  assign null_wr   = wr_cnt && (i_wdata == 32'h0);
  assign abort     = i_wr && (i_addr == C_OFS_ABORT) && i_wdata[C_ABORT_BIT];
  assign rd_fail   = s_r.rd_req && i_rd_ack && i_rd_err;
  assign wr_fail   = s_r.wr_req && i_wr_ack && i_wr_err;
  assign pace_en   = pif.pace && s_r.en;
  assign sniff_hit = s_r.sniff && i_sniff_on && (i_sniff_chan == C_CH_NUM);
  // a control write triggers on its own new enable value
  assign trigger   = (wr_ctrl && i_wdata[C_EN_BIT]) ||
                     ((i_chain_in || (wr_cnt && !null_wr)) && s_r.en);

  // ******************************************************
  // next state
  // ******************************************************
  always_comb begin
    s_nxt          = s_r;
    s_nxt.irq      = 1'b0;
    s_nxt.chain_go = 1'b0;
    s_nxt.sniff_v  = 1'b0;
    s_nxt.rdata    = 32'h0;

    if (i_rd) begin
      case (i_addr)
        C_OFS_SRC:  s_nxt.rdata = s_r.src;
        C_OFS_DST:  s_nxt.rdata = s_r.dst;
        C_OFS_CNT:  s_nxt.rdata = s_r.cnt;
        C_OFS_CTRL: s_nxt.rdata = ctrl_word(s_r);
        default:    s_nxt.rdata = 32'h0;
      endcase
    end

    if (i_wr && (i_addr == C_OFS_SRC)) begin
      s_nxt.src = i_wdata;
    end
    if (i_wr && (i_addr == C_OFS_DST)) begin
      s_nxt.dst = i_wdata;
    end
    if (wr_cnt && !null_wr) begin
      s_nxt.cnt = i_wdata;
    end
    if (null_wr && s_r.quiet) begin
      s_nxt.irq = 1'b1;
    end
    if (wr_ctrl) begin
      s_nxt.en        = i_wdata[C_EN_BIT];
      s_nxt.hipri     = i_wdata[C_HIPRI_BIT];
      s_nxt.size      = i_wdata[C_SIZE_LSB +: 2];
      s_nxt.src_step  = i_wdata[C_SRCSTEP_BIT];
      s_nxt.dst_step  = i_wdata[C_DSTSTEP_BIT];
      s_nxt.ring_size = i_wdata[C_RING_LSB +: 4];
      s_nxt.ring_sel  = i_wdata[C_RINGSEL_BIT];
      s_nxt.chain     = i_wdata[C_CHAIN_LSB +: 4];
      s_nxt.pace_sel  = i_wdata[C_PACE_LSB +: 6];
      s_nxt.quiet     = i_wdata[C_QUIET_BIT];
      s_nxt.brev      = i_wdata[C_BREV_BIT];
      s_nxt.sniff     = i_wdata[C_SNIFF_BIT];
      // clear first so that a fault in this same cycle still lands
      if (i_wdata[C_RDERR_BIT]) begin
        s_nxt.rd_err = 1'b0;
      end
      if (i_wdata[C_WRERR_BIT]) begin
        s_nxt.wr_err = 1'b0;
      end
    end

    // ******************************************************
    // transfer engine
    // ******************************************************
    case (s_r.state)
      CCS_IDLE: begin
        // a disabled channel issues nothing but keeps busy
        if (s_r.busy && s_r.en) begin
          if (s_r.cnt == 32'h0) begin
            s_nxt.busy = 1'b0;
            if (!s_r.quiet) begin
              s_nxt.irq = 1'b1;
            end
            if (s_r.chain != C_CH_NUM) begin
              s_nxt.chain_go = 1'b1;
            end
          end else if (pif.pace) begin
            s_nxt.rd_req = 1'b1;
            s_nxt.state  = CCS_READ;
          end
        end
      end
      CCS_READ: begin
        if (s_r.rd_req && i_rd_ack) begin
          s_nxt.rd_req = 1'b0;
          if (i_rd_err) begin
            // pointer left on the faulting transfer
            s_nxt.rd_err = 1'b1;
            s_nxt.busy   = 1'b0;
            s_nxt.irq    = 1'b1;
            s_nxt.state  = CCS_IDLE;
          end else begin
            s_nxt.data    = pif.data_out;
            s_nxt.src     = pif.src_next;
            s_nxt.sniff_v = sniff_hit;
            s_nxt.wr_req  = s_r.en;
            s_nxt.state   = CCS_WRITE;
          end
        end
      end
      CCS_WRITE: begin
        if (!s_r.wr_req) begin
          s_nxt.wr_req = s_r.en;
        end else if (i_wr_ack) begin
          s_nxt.wr_req = 1'b0;
          if (i_wr_err) begin
            s_nxt.wr_err = 1'b1;
            s_nxt.busy   = 1'b0;
            s_nxt.irq    = 1'b1;
          end else begin
            s_nxt.dst = pif.dst_next;
            s_nxt.cnt = s_r.cnt - 32'h1;
          end
          s_nxt.state = CCS_IDLE;
        end
      end
      default: begin
        s_nxt.state  = CCS_IDLE;
        s_nxt.rd_req = 1'b0;
        s_nxt.wr_req = 1'b0;
      end
    endcase

    if (abort) begin
      s_nxt.busy   = 1'b0;
      s_nxt.rd_req = 1'b0;
      s_nxt.wr_req = 1'b0;
      s_nxt.state  = CCS_IDLE;
    end else if (trigger && !s_r.busy) begin
      s_nxt.busy = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_r          <= '0;
      s_r.chain    <= C_CH_NUM;
      s_r.state    <= CCS_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata       = s_r.rdata;
  assign o_rd_req      = s_r.rd_req;
  assign o_rd_addr     = s_r.src;
  assign o_wr_req      = s_r.wr_req;
  assign o_wr_addr     = s_r.dst;
  assign o_wr_data     = s_r.data;
  assign o_size        = s_r.size;
  assign o_busy        = s_r.busy;
  assign o_irq         = s_r.irq;
  assign o_chain_go    = s_r.chain_go;
  assign o_chain_idx   = s_r.chain;
  assign o_sniff_valid = s_r.sniff_v;
  assign o_sniff_data  = s_r.data;

  // ******************************************************
  // checks
  // ******************************************************
  a_rd_fault_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    rd_fail |=> s_r.rd_err && o_irq && !o_busy)
    else $error("read fault not flagged");
  a_wr_fault_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_fail |=> s_r.wr_err && o_irq && !o_busy)
    else $error("write fault not flagged");
  a_fault_halts: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (rd_fail || wr_fail) && !trigger |=> !o_busy ##1 (!o_busy || $past(trigger)))
    else $error("channel ran on after a fault");
  a_rd_fault_addr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    rd_fail && !i_wr |=> $stable(o_rd_addr))
    else $error("source pointer moved on a read fault");
  a_err_summary: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_rd && (i_addr == C_OFS_CTRL) |=>
      o_rdata[C_ANYERR_BIT] == ($past(s_r.rd_err) | $past(s_r.wr_err)))
    else $error("error summary bit wrong");
  a_pause_busy: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_busy && !s_r.en && !abort && !rd_fail && !wr_fail |=> o_busy)
    else $error("busy dropped while paused");
  a_abort_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    abort |=> !o_busy && !o_rd_req && !o_wr_req)
    else $error("abort left channel busy");
  a_quiet_block: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_r.quiet && !null_wr && !rd_fail && !wr_fail |=> !o_irq)
    else $error("interrupt raised in quiet mode");
  a_pace_issue: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_rd_req) |-> $past(pace_en))
    else $error("read issued without pacing request");
  a_trig_start: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_ctrl && i_wdata[C_EN_BIT] && !o_busy && !abort |=> o_busy)
    else $error("control write did not start channel");

endmodule

// ==== common/ccs_pkg.sv ====
// constants and types for one dma channel's control and status logic
package ccs_pkg;

  localparam int          C_ADDR_W      = 12;
  // ******************************************************
  // register map
  // ******************************************************
  localparam logic [11:0] C_OFS_SRC     = 12'h1C0;
  localparam logic [11:0] C_OFS_DST     = 12'h1C4;
  localparam logic [11:0] C_OFS_CNT     = 12'h1C8;
  localparam logic [11:0] C_OFS_CTRL    = 12'h1CC;
  localparam logic [11:0] C_OFS_ABORT   = 12'h1D0;

  // ******************************************************
  // control and abort register fields
  // ******************************************************
  localparam int C_EN_BIT      = 0;
  localparam int C_HIPRI_BIT   = 1;
  localparam int C_SIZE_LSB    = 2;
  localparam int C_SRCSTEP_BIT = 4;
  localparam int C_DSTSTEP_BIT = 5;
  localparam int C_RING_LSB    = 6;
  localparam int C_RINGSEL_BIT = 10;
  localparam int C_CHAIN_LSB   = 11;
  localparam int C_PACE_LSB    = 15;
  localparam int C_QUIET_BIT   = 21;
  localparam int C_BREV_BIT    = 22;
  localparam int C_SNIFF_BIT   = 23;
  localparam int C_BUSY_BIT    = 24;
  localparam int C_WRERR_BIT   = 29;
  localparam int C_RDERR_BIT   = 30;
  localparam int C_ANYERR_BIT  = 31;
  localparam int C_ABORT_BIT   = 0;

  localparam logic [3:0]  C_CH_NUM      = 4'h7;
  localparam int          C_PERIPHERAL_DATA_REQUEST_N      = 59;
  localparam logic [5:0]  C_PACE_PERIPHERAL_DATA_REQUEST_MAX = 6'h3A;
  localparam logic [5:0]  C_PACE_TMR0   = 6'h3B;
  localparam logic [5:0]  C_PACE_TMR3   = 6'h3E;
  localparam logic [5:0]  C_PACE_ALWAYS = 6'h3F;
  localparam logic [1:0]  C_SIZE_BYTE   = 2'h0;
  localparam logic [1:0]  C_SIZE_HALF   = 2'h1;
  localparam logic [1:0]  C_SIZE_WORD   = 2'h2;

  typedef enum logic [1:0] {
    CCS_IDLE  = 2'b00,
    CCS_READ  = 2'b01,
    CCS_WRITE = 2'b11
  } ccs_state_t;

endpackage

// ==== common/ccs_path_if.sv ====
// carrier between the channel controller and its data/address path
interface ccs_path_if;
  import ccs_pkg::*;
  logic [1:0]          size;
  logic                brev;
  logic [3:0]          ring_size;
  logic                ring_sel;
  logic                src_step;
  logic                dst_step;
  logic [31:0]         src;
  logic [31:0]         dst;
  logic [31:0]         raw_data;
  logic [5:0]          pace_sel;
  logic [C_PERIPHERAL_DATA_REQUEST_N-1:0] peripheral_data_request;
  logic [3:0]          timer;
  logic                pace;
  logic [31:0]         src_next;
  logic [31:0]         dst_next;
  logic [31:0]         data_out;

  modport ctrl (output size, brev, ring_size, ring_sel, src_step, dst_step, src, dst,
                output raw_data, pace_sel, peripheral_data_request, timer,
                input  pace, src_next, dst_next, data_out);
  modport path (input  size, brev, ring_size, ring_sel, src_step, dst_step, src, dst,
                input  raw_data, pace_sel, peripheral_data_request, timer,
                output pace, src_next, dst_next, data_out);
endinterface

// ==== hdl/ccs_xfer_path.sv ====
// pacing select, pointer stepping with ring wrap, and byte reversal
module ccs_xfer_path (
  ccs_path_if.path bus
);
  import ccs_pkg::*;

  // one step of a pointer, kept inside a 2^n ring when this side wraps
  function automatic logic [31:0] step_addr(input logic [31:0] a,
                                            input logic        on,
                                            input logic        wrap,
                                            input logic [1:0]  size,
                                            input logic [3:0]  n);
    logic [31:0] inc;
    logic [31:0] sum;
    logic [31:0] mask;
    inc  = 32'h1 << size;
    sum  = a + inc;
    mask = (32'h1 << n) - 32'h1;
    if (!on) begin
      step_addr = a;
    end else if (wrap && (n != 4'h0)) begin
      step_addr = (a & ~mask) | (sum & mask);
    end else begin
      step_addr = sum;
    end
  endfunction

  logic [5:0] tmr_idx;

  always_comb begin
    tmr_idx      = bus.pace_sel - C_PACE_TMR0;
    bus.src_next = step_addr(bus.src, bus.src_step, !bus.ring_sel, bus.size,
                             bus.ring_size);
    bus.dst_next = step_addr(bus.dst, bus.dst_step, bus.ring_sel, bus.size,
                             bus.ring_size);
    if (bus.pace_sel <= C_PACE_PERIPHERAL_DATA_REQUEST_MAX) begin
      bus.pace = bus.peripheral_data_request[bus.pace_sel];
    end else if (bus.pace_sel <= C_PACE_TMR3) begin
      bus.pace = bus.timer[tmr_idx[1:0]];
    end else begin
      bus.pace = 1'b1;
    end
    bus.data_out = bus.raw_data;
    if (bus.brev) begin
      case (bus.size)
        C_SIZE_HALF: bus.data_out = {bus.raw_data[23:16], bus.raw_data[31:24],
                                     bus.raw_data[7:0], bus.raw_data[15:8]};
        C_SIZE_WORD: bus.data_out = {bus.raw_data[7:0], bus.raw_data[15:8],
                                     bus.raw_data[23:16], bus.raw_data[31:24]};
        default:     bus.data_out = bus.raw_data;
      endcase
    end
  end

endmodule

// ==== bench/ccs_mem_model.sv ====
// bus memory model with injectable read and write faults
module ccs_mem_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic [3:0]  i_dly,
  input  wire logic        i_rd_bad,
  input  wire logic        i_wr_bad,
  input  wire logic        i_rd_req,
  input  wire logic [31:0] i_rd_addr,
  input  wire logic        i_wr_req,
  input  wire logic [31:0] i_wr_data,
  output logic             o_rd_ack,
  output logic             o_rd_err,
  output logic [31:0]      o_rd_data,
  output logic             o_wr_ack,
  output logic             o_wr_err,
  output logic [31:0]      o_last_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] rc;
  logic [3:0] wc;
  logic       rgo;
  logic       wgo;
  // one answer per request, after i_dly wait cycles
  assign rgo = i_rd_req && !o_rd_ack && rc >= i_dly;
  assign wgo = i_wr_req && !o_wr_ack && wc >= i_dly;
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      {rc, wc, o_rd_ack, o_rd_err, o_wr_ack, o_wr_err} <= '0;
      o_rd_data <= '0;
      o_last_wr <= '0;
    end else begin
      o_rd_ack <= rgo;
      o_rd_err <= rgo && i_rd_bad;
      o_wr_ack <= wgo;
      o_wr_err <= wgo && i_wr_bad;
      rc <= (i_rd_req && !o_rd_ack) ? rc + 4'h1 : 4'h0;
      wc <= (i_wr_req && !o_wr_ack) ? wc + 4'h1 : 4'h0;
      // data lines toggle when no answer is carried
      o_rd_data <= rgo ? {~i_rd_addr[15:0], i_rd_addr[15:0]} : ~o_rd_data;
      if (wgo) begin
        o_last_wr <= i_wr_data;
      end
    end
  end
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for one dma channel's control and status block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ccs_pkg::*;
  typedef struct packed {logic [31:0] c, s, d, w; logic [1:0] n; logic k;} ccs_row_t;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [11:0] i_addr = '0;
  logic [31:0] i_wdata = '0, o_rdata, o_rd_addr, o_wr_addr, o_wr_data, o_sniff_data;
  logic [C_PERIPHERAL_DATA_REQUEST_N-1:0] i_peripheral_data_request = '0;
  logic [3:0] i_timer = '0, o_chain_idx, dly = '0, sn_ch = 4'h7;
  logic i_rd_ack, i_rd_err, i_wr_ack, i_wr_err, o_rd_req, o_wr_req, o_busy, o_irq;
  logic o_chain_go, o_sniff_valid, rd_bad = 1'b0, wr_bad = 1'b0, sn_on = 1'b1, ch_in = 1'b0;
  logic [31:0] i_rd_data, last_wr, rv, sn_last = '0;
  logic [1:0] o_size;
  int miscompares = 0, checks = 0, cyc = 0, n_irq = 0, n_ch = 0, n_sn = 0, b_i, b_c, b_s;
  ccs_row_t rows [5] = '{
    '{32'h009FB839, 32'h1008, 32'h2008, 32'hEFFB1004, 2'h2, 1'b1},
    '{32'h005FB839, 32'h1008, 32'h2008, 32'h0410FBEF, 2'h0, 1'b1},
    '{32'h001FB815, 32'h1004, 32'h2000, 32'h0, 2'h0, 1'b0},
    '{32'h001FBC61, 32'h1000, 32'h2000, 32'h0, 2'h0, 1'b0},
    '{32'h001FB8F9, 32'h1000, 32'h2008, 32'hEFFB1004, 2'h0, 1'b1}};
  logic [5:0] sels [6] = '{6'h00, 6'h3A, 6'h3B, 6'h3C, 6'h3D, 6'h3E};

  ccs_channel i_ccs_channel (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_peripheral_data_request, .i_timer, .i_chain_in(ch_in), .i_sniff_on(sn_on), .i_sniff_chan(sn_ch),
    .o_rd_req, .o_rd_addr, .i_rd_ack, .i_rd_err, .i_rd_data, .o_wr_req, .o_wr_addr,
    .o_wr_data, .i_wr_ack, .i_wr_err, .o_size, .o_busy, .o_irq, .o_chain_go, .o_chain_idx,
    .o_sniff_valid, .o_sniff_data);
  ccs_mem_model i_ccs_mem_model (.i_sys_clk, .i_rst, .i_dly(dly), .i_rd_bad(rd_bad),
    .i_wr_bad(wr_bad), .i_rd_req(o_rd_req), .i_rd_addr(o_rd_addr), .i_wr_req(o_wr_req),
    .i_wr_data(o_wr_data), .o_rd_ack(i_rd_ack), .o_rd_err(i_rd_err),
    .o_rd_data(i_rd_data), .o_wr_ack(i_wr_ack), .o_wr_err(i_wr_err), .o_last_wr(last_wr));

  always #10 i_sys_clk = ~i_sys_clk;
  // event counters; tests compare differences, never absolute values
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    n_irq <= n_irq + int'(o_irq === 1'b1);
    n_ch <= n_ch + int'(o_chain_go === 1'b1);
    n_sn <= n_sn + int'(o_sniff_valid === 1'b1);
    if (o_sniff_valid === 1'b1) sn_last <= o_sniff_data;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // strobe one cycle, then one idle edge so no signal is set twice at once
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 q = o_rdata;
    @(posedge i_sys_clk);
  endtask
  task automatic run(input logic [31:0] c, input logic [31:0] n);
    b_i = n_irq;
    b_c = n_ch;
    b_s = n_sn;
    wr(C_OFS_CTRL, 32'h3800);
    wr(C_OFS_SRC, 32'h1000);
    wr(C_OFS_DST, 32'h2000);
    wr(C_OFS_CNT, n);
    wr(C_OFS_CTRL, c);
  endtask
  task automatic idle();
    while (o_busy !== 1'b0) @(negedge i_sys_clk);
    // second edge lets the event counters take the closing pulses
    repeat (2) @(posedge i_sys_clk);
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ******************************************************
  // main sequence
  // ******************************************************
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    rd(C_OFS_CTRL, rv);
    chk(rv, 32'h3800);
    chk(o_chain_idx, 4'h7);
    wr(C_OFS_CTRL, 32'h1F003800);
    rd(C_OFS_CTRL, rv);
    chk(rv, 32'h3800);
    rd(12'h1D4, rv);
    chk(rv, 32'h0);
    $display("reset and reserved test done");
    foreach (rows[k]) begin
      run(rows[k].c, 32'h2);
      idle();
      chk(o_rd_addr, rows[k].s);
      chk(o_wr_addr, rows[k].d);
      chk(o_size, rows[k].c[3:2]);
      if (rows[k].n != 2'h0) chk(sn_last, rows[k].w);
      rd(C_OFS_SRC, rv);
      chk(rv, rows[k].s);
      rd(C_OFS_DST, rv);
      chk(rv, rows[k].d);
      if (rows[k].k) chk(last_wr, rows[k].w);
      chk(n_sn - b_s, rows[k].n);
      chk(n_irq - b_i, 1);
      rd(C_OFS_CTRL, rv);
      chk(rv, rows[k].c);
      $display("row %0d done", k);
    end
    // checksum unit off, then pointed at another channel: nothing presented
    for (int j = 0; j < 2; j++) begin
      sn_on <= (j == 1);
      sn_ch <= (j == 1) ? 4'h3 : 4'h7;
      run(rows[0].c, 32'h2);
      idle();
      chk(n_sn - b_s, 0);
    end
    sn_on <= 1'b1;
    sn_ch <= 4'h7;
    $display("sniff select test done");
    foreach (sels[k]) begin
      run({11'h000, sels[k], 4'h3, 11'h039}, 32'h1);
      repeat (10) @(negedge i_sys_clk);
      chk(o_busy, 1'b1);
      chk(o_rd_req, 1'b0);
      @(posedge i_sys_clk);
      if (sels[k] <= C_PACE_PERIPHERAL_DATA_REQUEST_MAX) i_peripheral_data_request[sels[k]] <= 1'b1;
      else i_timer[sels[k] - C_PACE_TMR0] <= 1'b1;
      idle();
      i_peripheral_data_request <= '0;
      i_timer <= '0;
      chk(n_ch - b_c, 1);
      chk(o_chain_idx, 4'h3);
    end
    $display("pace and chain test done");
    run(32'h003FB839, 32'h1);
    idle();
    chk(n_irq - b_i, 0);
    wr(C_OFS_CNT, 32'h0);
    repeat (2) @(posedge i_sys_clk);
    chk(n_irq - b_i, 1);
    $display("quiet test done");
    for (int e = 0; e < 2; e++) begin
      rd_bad <= (e == 0);
      wr_bad <= (e == 1);
      run(32'h001FB839, 32'h3);
      idle();
      rd_bad <= 1'b0;
      wr_bad <= 1'b0;
      chk(n_irq - b_i, 1);
      rd(C_OFS_CTRL, rv);
      chk(rv[31:29], e ? 3'b101 : 3'b110);
      rd(e ? C_OFS_DST : C_OFS_SRC, rv);
      chk(rv[31:12] == (e ? 20'h2 : 20'h1) && rv[11:0] <= (e ? 12'h14 : 12'hC), 1);
      wr(C_OFS_CTRL, e ? 32'h20003800 : 32'h40003800);
      rd(C_OFS_CTRL, rv);
      chk(rv, 32'h3800);
    end
    $display("bus error test done");
    dly <= 4'h3;
    run(32'h001FB839, 32'h4);
    repeat (6) @(posedge i_sys_clk);
    wr(C_OFS_CTRL, 32'h001FB838);
    repeat (12) @(negedge i_sys_clk);
    chk(o_busy, 1'b1);
    chk({o_rd_req, o_wr_req}, 2'b00);
    @(posedge i_sys_clk);
    wr(C_OFS_CTRL, 32'h001FB839);
    idle();
    rd(C_OFS_DST, rv);
    chk(rv, 32'h2010);
    dly <= 4'h0;
    $display("pause test done");
    run(32'h00003839, 32'h5);
    @(negedge i_sys_clk);
    chk(o_busy, 1'b1);
    @(posedge i_sys_clk);
    wr(C_OFS_ABORT, 32'h1);
    repeat (2) @(negedge i_sys_clk);
    chk(o_busy, 1'b0);
    @(posedge i_sys_clk);
    ch_in <= 1'b1;
    @(posedge i_sys_clk);
    ch_in <= 1'b0;
    @(negedge i_sys_clk);
    chk(o_busy, 1'b1);
    $display("abort test done");
    test_done();
  end
endmodule
